// File: core/cpu_bus_state_control.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - one state is one clock period; every bus cycle spans two or three states
// - memory accesses take two states on a 16-bit path, byte or word
// - peripheral accesses take two or three states, byte only on 8 bits
// - exactly four states: reset, execution, halt, exception handling
// - execution runs on system clock in active modes, subclock in subactive
// - halt has sleep, standby, watch, subsleep; no instructions execute there
// - exception on reset or interrupt; interrupt pushes counter and flags via R7
// - writes to unpopulated space are discarded and flagged
// - reads from unpopulated space return undefined data
// - word write to I/O: upper byte reaches register, lower byte dropped
// - word read from I/O: byte goes high, low half undefined
// - bit operations read the byte, change one bit, write the byte back
// - shared address: read returns counter, write lands in reload register
// - port data read gives pin level for inputs, latch for outputs
// - write-only register reads as all ones
module cpu_bus_state_control
  import cpu_bus_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // state control
  input wire logic IRQ,
  input wire logic SLEEP_REQ,
  input wire logic [1:0] HALT_MODE_REQ,
  input wire logic WAKE,
  input wire logic [1:0] EXEC_MODE_REQ,
  input wire logic [15:0] PC,
  input wire logic [7:0] CONDITION_FLAGS,
  input wire logic [15:0] STACK_POINTER,
  output logic [1:0] CPU_STATE,
  output logic [1:0] EXEC_MODE,
  output logic [1:0] HALT_MODE,
  output logic SUBCLK_SEL,
  output logic EXC_DONE,
  output logic [15:0] EXC_STACK_POINTER,
  // access request
  input wire logic REQ,
  output logic READY,
  input wire logic WRITE,
  input wire logic WORD,
  input wire logic [15:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic BIT_EN,
  input wire logic [2:0] BIT_OP,
  input wire logic [2:0] BIT_NUM,
  input wire logic BIT_C,
  output logic DONE,
  output logic [15:0] RDATA,
  output logic EMPTY_WRITE,
  // on-chip memory
  output logic MEM_SEL,
  output logic MEM_WE,
  output logic [1:0] MEM_BE,
  output logic [15:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  input wire logic [15:0] MEM_RDATA,
  // peripheral bus
  output logic PER_SEL,
  output logic PER_WE,
  output logic [15:0] PER_ADDR,
  output logic [7:0] PER_WDATA,
  input wire logic [7:0] PER_RDATA,
  // port pins
  input wire logic [7:0] PORT_PIN_IN,
  output logic [7:0] PORT_OUT,
  output logic [7:0] PORT_OE
);
  cpu_state_t cpu_state;
  bus_state_t bus_state;
  region_t cur_region;
  logic [15:0] cur_addr, cur_wdata;
  logic cur_write, cur_word, cur_slow, cur_rmw, cur_exc, rmw_phase, cur_c;
  logic [2:0] cur_op, cur_num;
  logic exc_irq;
  logic [1:0] exc_step;
  logic take_cpu, take_exc, last_state, port_hit;
  logic [7:0] port_rdata, io_byte, mem_byte;

  function automatic region_t region_of(input logic [15:0] a);
    if (a <= ROM_LAST) return RG_ROM;
    if (a >= RAM_FIRST && a <= RAM_LAST) return RG_RAM;
    if (a >= IO_FIRST) return RG_IO;
    return RG_EMPTY;
  endfunction

  function automatic logic is_port(input logic [15:0] a);
    return (a == PORT_DATA_ADDR) || (a == PORT_DIR_ADDR);
  endfunction

  function automatic logic slow_io(input logic [15:0] a);
    return (a >= IO_SLOW_FIRST) && (a <= IO_SLOW_LAST);
  endfunction

  function automatic logic [7:0] bit_modify(input logic [7:0] d, input logic [2:0] op,
                                            input logic [2:0] n, input logic c);
    logic [7:0] r;
    r = d;
    case (op)
      BIT_SET_OP: r[n] = 1'b1;
      BIT_CLEAR_OP: r[n] = 1'b0;
      BIT_INVERT_OP: r[n] = ~d[n];
      BIT_STORE_OP: r[n] = c;
      BIT_INVERTED_STORE_OP: r[n] = ~c;
      default: r = d;
    endcase
    return r;
  endfunction

  // request acceptance: only while executing with the bus free
  assign READY = (cpu_state == CPU_EXEC) && (bus_state == BUS_IDLE) && !IRQ;
  assign take_cpu = READY && REQ;
  assign take_exc = (cpu_state == CPU_EXCEPT) && exc_irq && (bus_state == BUS_IDLE) &&
                    (exc_step < EXC_PUSHES);
  assign last_state = (bus_state == BUS_T2);
  assign port_hit = (cur_region == RG_IO) && is_port(cur_addr);

  // processor state machine
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cpu_state <= CPU_RESET;
      exc_irq <= 1'b0;
      exc_step <= 2'h0;
      HALT_MODE <= HALT_SLEEP;
      EXC_DONE <= 1'b0;
      EXC_STACK_POINTER <= 16'h0000;
    end else begin
      EXC_DONE <= 1'b0;
      case (cpu_state)
        CPU_RESET: begin
          cpu_state <= CPU_EXCEPT;
          exc_irq <= 1'b0;
        end
        CPU_EXEC: begin
          if (bus_state == BUS_IDLE && IRQ) begin
            cpu_state <= CPU_EXCEPT;
            exc_irq <= 1'b1;
            exc_step <= 2'h0;
          end else if (bus_state == BUS_IDLE && SLEEP_REQ && !REQ) begin
            cpu_state <= CPU_HALT;
            HALT_MODE <= HALT_MODE_REQ;
          end
        end
        CPU_HALT: begin
          if (IRQ) begin
            cpu_state <= CPU_EXCEPT;
            exc_irq <= 1'b1;
            exc_step <= 2'h0;
          end else if (WAKE) begin
            cpu_state <= CPU_EXEC;
          end
        end
        CPU_EXCEPT: begin
          if (take_exc) begin
            exc_step <= exc_step + 2'h1;
          end else if (bus_state == BUS_IDLE && (!exc_irq || exc_step == EXC_PUSHES)) begin
            cpu_state <= CPU_EXEC;
            EXC_DONE <= 1'b1;
            if (exc_irq) begin
              EXC_STACK_POINTER <= STACK_POINTER - STACK_STEP - STACK_STEP;
            end
            exc_irq <= 1'b0;
          end
        end
        default: cpu_state <= CPU_RESET;
      endcase
    end
  end

  // running mode and clock source
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      EXEC_MODE <= EXEC_HIGH;
      SUBCLK_SEL <= 1'b0;
    end else begin
      if (cpu_state == CPU_EXEC) begin
        EXEC_MODE <= EXEC_MODE_REQ;
      end
      SUBCLK_SEL <= (cpu_state == CPU_EXEC && EXEC_MODE == EXEC_SUB) ||
                    (cpu_state == CPU_HALT && HALT_MODE == HALT_SUBSLEEP);
    end
  end
  assign CPU_STATE = cpu_state;

  // bus sequencer: T1, optional wait, T2; one state per clock
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      bus_state <= BUS_IDLE;
    end else begin
      case (bus_state)
        BUS_IDLE: if (take_cpu || take_exc) bus_state <= BUS_T1;
        BUS_T1: bus_state <= (cur_region == RG_IO && cur_slow) ? BUS_TW : BUS_T2;
        BUS_TW: bus_state <= BUS_T2;
        BUS_T2: bus_state <= (cur_rmw && !rmw_phase) ? BUS_T1 : BUS_IDLE;
        default: bus_state <= BUS_IDLE;
      endcase
    end
  end

  // access capture and read-modify-write turnaround
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cur_addr <= 16'h0000;
      cur_wdata <= 16'h0000;
      cur_region <= RG_EMPTY;
      {cur_write, cur_word, cur_slow, cur_rmw, cur_exc, rmw_phase, cur_c} <= 7'h00;
      cur_op <= 3'h0;
      cur_num <= 3'h0;
    end else if (take_exc) begin
      // stack pushes: counter first, then flags
      cur_addr <= STACK_POINTER -
                  ((exc_step == 2'h0) ? STACK_STEP : STACK_STEP + STACK_STEP);
      cur_wdata <= (exc_step == 2'h0) ? PC : {CONDITION_FLAGS, CONDITION_FLAGS};
      cur_region <= region_of(STACK_POINTER - STACK_STEP);
      {cur_write, cur_word, cur_exc, cur_rmw, rmw_phase} <= 5'h1c;
      cur_slow <= 1'b0;
    end else if (take_cpu) begin
      cur_addr <= ADDR;
      cur_wdata <= WDATA;
      cur_region <= region_of(ADDR);
      cur_slow <= slow_io(ADDR);
      cur_write <= WRITE && !BIT_EN;
      cur_word <= WORD && !BIT_EN;
      cur_rmw <= BIT_EN;
      cur_exc <= 1'b0;
      rmw_phase <= 1'b0;
      cur_op <= BIT_OP;
      cur_num <= BIT_NUM;
      cur_c <= BIT_C;
    end else if (last_state && cur_rmw && !rmw_phase) begin
      // same address is reused so a shared address writes its reload half
      cur_wdata <= {8'h00, bit_modify(cur_region == RG_IO ? io_byte : mem_byte,
                                      cur_op, cur_num, cur_c)};
      cur_write <= 1'b1;
      rmw_phase <= 1'b1;
    end
  end

  // read byte selection
  assign io_byte = port_hit ? port_rdata : PER_RDATA;
  assign mem_byte = cur_addr[0] ? MEM_RDATA[7:0] : MEM_RDATA[15:8];

  // read data, completion and empty-area flag
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      RDATA <= 16'h0000;
      DONE <= 1'b0;
      EMPTY_WRITE <= 1'b0;
    end else begin
      DONE <= last_state && !cur_exc && !(cur_rmw && !rmw_phase);
      EMPTY_WRITE <= last_state && cur_write && cur_region == RG_EMPTY;
      if (last_state && !cur_write) begin
        case (cur_region)
          RG_ROM, RG_RAM: RDATA <= cur_word ? MEM_RDATA : {8'h00, mem_byte};
          RG_IO: RDATA <= cur_word ? {io_byte, UNDEF_BYTE} : {8'h00, io_byte};
          default: RDATA <= {UNDEF_BYTE, UNDEF_BYTE};
        endcase
      end
    end
  end

  // memory strobes; empty area gets no strobe so writes are lost
  assign MEM_SEL = (bus_state != BUS_IDLE) && (cur_region == RG_ROM || cur_region == RG_RAM);
  assign MEM_WE = MEM_SEL && cur_write;
  assign MEM_ADDR = cur_addr;
  assign MEM_BE = cur_word ? 2'b11 : (cur_addr[0] ? 2'b01 : 2'b10);
  assign MEM_WDATA = cur_word ? cur_wdata : {cur_wdata[7:0], cur_wdata[7:0]};

  // peripheral strobes; a word write carries only its upper byte
  assign PER_SEL = (bus_state != BUS_IDLE) && (cur_region == RG_IO) && !port_hit;
  assign PER_WE = PER_SEL && cur_write;
  assign PER_ADDR = cur_addr;
  assign PER_WDATA = cur_word ? cur_wdata[15:8] : cur_wdata[7:0];

  port_data_unit u_port (
    .CLK_SYS(CLK_SYS),
    .RST(RST),
    .sel_dir(cur_addr == PORT_DIR_ADDR),
    .wr(last_state && port_hit && cur_write),
    .wdata(PER_WDATA),
    .rdata(port_rdata),
    .pin_in(PORT_PIN_IN),
    .port_out(PORT_OUT),
    .port_oe(PORT_OE)
  );

  // checks
  AST_MEM_TWO: assert property (@(posedge CLK_SYS) disable iff (RST)
    (bus_state == BUS_T1 && MEM_SEL) |=> bus_state == BUS_T2 ##1 bus_state != BUS_TW)
    else $error("memory cycle not two states");
  AST_IO_SLOW: assert property (@(posedge CLK_SYS) disable iff (RST)
    (bus_state == BUS_T1 && cur_region == RG_IO && cur_slow) |=>
      bus_state == BUS_TW ##1 bus_state == BUS_T2)
    else $error("slow peripheral cycle not three states");
  AST_IO_FAST: assert property (@(posedge CLK_SYS) disable iff (RST)
    (bus_state == BUS_T1 && cur_region == RG_IO && !cur_slow) |=> bus_state == BUS_T2)
    else $error("fast peripheral cycle not two states");
  AST_WORD_IO_WR: assert property (@(posedge CLK_SYS) disable iff (RST)
    (take_cpu && WRITE && WORD && !BIT_EN && region_of(ADDR) == RG_IO && !is_port(ADDR))
      |=> PER_WE && PER_WDATA == $past(WDATA[15:8]))
    else $error("word write to peripheral lost upper byte");
  AST_EMPTY_WR: assert property (@(posedge CLK_SYS) disable iff (RST)
    (take_cpu && WRITE && !BIT_EN && region_of(ADDR) == RG_EMPTY) |=>
      (!MEM_WE && !PER_WE) [*2] ##1 (DONE && EMPTY_WRITE))
    else $error("empty-area write not dropped");
  AST_EMPTY_RD: assert property (@(posedge CLK_SYS) disable iff (RST)
    (take_cpu && !WRITE && !BIT_EN && region_of(ADDR) == RG_EMPTY) |->
      ##3 (DONE && RDATA == {UNDEF_BYTE, UNDEF_BYTE}))
    else $error("empty-area read value wrong");
  AST_WORD_IO_RD: assert property (@(posedge CLK_SYS) disable iff (RST)
    (take_cpu && !WRITE && WORD && !BIT_EN && region_of(ADDR) == RG_IO &&
     !is_port(ADDR) && !slow_io(ADDR)) |->
      ##3 (DONE && RDATA == {$past(PER_RDATA), UNDEF_BYTE}))
    else $error("word read from peripheral wrong");
  AST_RMW_B2B: assert property (@(posedge CLK_SYS) disable iff (RST)
    (last_state && cur_rmw && !rmw_phase) |=>
      (bus_state == BUS_T1 && cur_write && !cur_word && !READY))
    else $error("bit operation write not back to back");
  AST_WO_READ: assert property (@(posedge CLK_SYS) disable iff (RST)
    (take_cpu && !WRITE && !WORD && !BIT_EN && ADDR == PORT_DIR_ADDR) |->
      ##3 (DONE && RDATA[7:0] == WO_READ))
    else $error("write-only register not read as ones");
  AST_HALT_IDLE: assert property (@(posedge CLK_SYS) disable iff (RST)
    (cpu_state == CPU_HALT) |-> (!READY && bus_state == BUS_IDLE))
    else $error("bus active while halted");
  AST_RESET_EXC: assert property (@(posedge CLK_SYS) disable iff (RST)
    (cpu_state == CPU_RESET) |=> cpu_state == CPU_EXCEPT ##1 cpu_state == CPU_EXEC)
    else $error("reset does not pass through exception handling");
  AST_IRQ_PUSH: assert property (@(posedge CLK_SYS) disable iff (RST)
    (cpu_state == CPU_EXEC && bus_state == BUS_IDLE && IRQ) |=>
      ##[6:8] (EXC_DONE && EXC_STACK_POINTER == STACK_POINTER - 16'h0004))
    else $error("interrupt stack push not completed");
  COV_RMW: cover property (@(posedge CLK_SYS) disable iff (RST)
    last_state && cur_rmw && rmw_phase);
  COV_SLOW: cover property (@(posedge CLK_SYS) disable iff (RST) bus_state == BUS_TW);
  COV_EXC: cover property (@(posedge CLK_SYS) disable iff (RST)
    exc_irq && cpu_state == CPU_EXCEPT ##1 EXC_DONE);
  COV_HALT: cover property (@(posedge CLK_SYS) disable iff (RST)
    cpu_state == CPU_HALT ##1 cpu_state == CPU_EXEC);
endmodule
`default_nettype wire

// File: core/cpu_bus_pkg.sv
package cpu_bus_pkg;
  // top-level processor states
  typedef enum logic [1:0] {
    CPU_RESET  = 2'b00,
    CPU_EXEC   = 2'b01,
    CPU_HALT   = 2'b10,
    CPU_EXCEPT = 2'b11
  } cpu_state_t;
  // internal bus sequencer states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_T1   = 2'b01,
    BUS_TW   = 2'b10,
    BUS_T2   = 2'b11
  } bus_state_t;
  // running modes and halt sub-modes
  typedef enum logic [1:0] {
    EXEC_HIGH = 2'b00,
    EXEC_MED  = 2'b01,
    EXEC_SUB  = 2'b10
  } exec_mode_t;
  typedef enum logic [1:0] {
    HALT_SLEEP    = 2'b00,
    HALT_STANDBY  = 2'b01,
    HALT_WATCH    = 2'b10,
    HALT_SUBSLEEP = 2'b11
  } halt_mode_t;
  // single-bit operations
  typedef enum logic [2:0] {
    BIT_SET_OP            = 3'b000,
    BIT_CLEAR_OP          = 3'b001,
    BIT_INVERT_OP         = 3'b010,
    BIT_STORE_OP          = 3'b011,
    BIT_INVERTED_STORE_OP = 3'b100
  } bit_op_t;
  // address regions
  typedef enum logic [1:0] {
    RG_ROM   = 2'b00,
    RG_RAM   = 2'b01,
    RG_IO    = 2'b10,
    RG_EMPTY = 2'b11
  } region_t;
  // address map
  localparam logic [15:0] ROM_LAST = 16'h7fff;
  localparam logic [15:0] RAM_FIRST = 16'hf780;
  localparam logic [15:0] RAM_LAST = 16'hff7f;
  localparam logic [15:0] IO_FIRST = 16'hff80;
  localparam logic [15:0] IO_SLOW_FIRST = 16'hffa0;
  localparam logic [15:0] IO_SLOW_LAST = 16'hffbf;
  localparam logic [15:0] PORT_DATA_ADDR = 16'hffd9;
  localparam logic [15:0] PORT_DIR_ADDR = 16'hffe9;
  // fixed read values, reset values and exception stack constants
  localparam logic [7:0] UNDEF_BYTE = 8'h00;
  localparam logic [7:0] WO_READ = 8'hff;
  localparam logic [7:0] PORT_LATCH_RST = 8'h00;
  localparam logic [7:0] PORT_DIR_RST = 8'h00;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [1:0] EXC_PUSHES = 2'h2;
endpackage

// File: core/port_data_unit.sv
`timescale 1ns/1ps
`default_nettype none
module port_data_unit
  import cpu_bus_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // register access
  input wire logic sel_dir,
  input wire logic wr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // pins
  input wire logic [7:0] pin_in,
  output logic [7:0] port_out,
  output logic [7:0] port_oe
);
  logic [7:0] port_data_latch;
  logic [7:0] port_direction_control;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [7:0] data_view;

  // two-stage synchroniser on the pins
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // latch and direction, written at the end of the write state
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      port_data_latch <= PORT_LATCH_RST;
      port_direction_control <= PORT_DIR_RST;
    end else if (wr) begin
      if (sel_dir) begin
        port_direction_control <= wdata;
      end else begin
        port_data_latch <= wdata;
      end
    end
  end

  // inputs show the pin, outputs show the latch
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_view
      assign data_view[i] = port_direction_control[i] ? port_data_latch[i] : pin_sync[i];
    end
  endgenerate

  // direction register is write-only and reads as all ones
  assign rdata = sel_dir ? WO_READ : data_view;
  assign port_out = port_data_latch;
  assign port_oe = port_direction_control;
endmodule
`default_nettype wire

// File: bench/mem_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural on-chip memory and peripheral modules on the far side
module mem_periph_model #(
  parameter logic [15:0] TMR_ADDR = 16'hff90,
  parameter logic [7:0] TMR_COUNT = 8'h3c
) (
  // clock
  input wire logic clk,
  // memory side
  input wire logic mem_sel,
  input wire logic mem_we,
  input wire logic [1:0] mem_be,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  // peripheral side
  input wire logic per_sel,
  input wire logic per_we,
  input wire logic [15:0] per_addr,
  input wire logic [7:0] per_wdata,
  output logic [7:0] per_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] regs [0:127];
  logic [7:0] reload = 8'h00;
  logic [15:0] mem_last = 16'h0000;
  logic [7:0] per_last = 8'h00;
  logic [15:0] ev;
  assign ev = {mem_addr[15:1], 1'b0};
  // stores at each strobed edge; the even byte rides the upper lane
  always @(posedge clk) begin
    if (mem_sel && mem_we && mem_be[1]) mem[ev] <= mem_wdata[15:8];
    if (mem_sel && mem_we && mem_be[0]) mem[ev | 16'h0001] <= mem_wdata[7:0];
    if (per_sel && per_we && per_addr == TMR_ADDR) reload <= per_wdata;
    if (per_sel && per_we && per_addr != TMR_ADDR) regs[per_addr[6:0]] <= per_wdata;
    if (mem_sel) mem_last <= mem_rdata;
    if (per_sel) per_last <= per_rdata;
  end
  // released buses show the inverse of the last value; the timer reads its count
  assign mem_rdata = mem_sel ? {mem[ev], mem[ev | 16'h0001]} : ~mem_last;
  assign per_rdata = !per_sel ? ~per_last :
                     (per_addr == TMR_ADDR) ? TMR_COUNT : regs[per_addr[6:0]];
endmodule
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cpu_bus_pkg::*;
  logic CLK_SYS, RST, IRQ, SLEEP_REQ, WAKE, REQ, WRITE, WORD, BIT_EN, BIT_C, READY, DONE;
  logic SUBCLK_SEL, EXC_DONE, EMPTY_WRITE, MEM_SEL, MEM_WE, PER_SEL, PER_WE;
  logic [1:0] HALT_MODE_REQ, EXEC_MODE_REQ, CPU_STATE, EXEC_MODE, HALT_MODE, MEM_BE;
  logic [15:0] PC, STACK_POINTER, ADDR, WDATA, MEM_RDATA, EXC_STACK_POINTER, RDATA, MEM_ADDR;
  logic [15:0] MEM_WDATA, PER_ADDR;
  logic [7:0] CONDITION_FLAGS, PER_RDATA, PORT_PIN_IN, PER_WDATA, PORT_OUT, PORT_OE;
  logic [2:0] BIT_OP, BIT_NUM;
  logic ew;
  logic [15:0] rd;
  int miscompares = 0;
  int cmp_count = 0;
  // design and far-side model
  cpu_bus_state_control u_cpu_bus_state_control (
    .CLK_SYS(CLK_SYS), .RST(RST), .IRQ(IRQ), .SLEEP_REQ(SLEEP_REQ),
    .HALT_MODE_REQ(HALT_MODE_REQ), .WAKE(WAKE), .EXEC_MODE_REQ(EXEC_MODE_REQ), .PC(PC),
    .CONDITION_FLAGS(CONDITION_FLAGS), .STACK_POINTER(STACK_POINTER), .CPU_STATE(CPU_STATE),
    .EXEC_MODE(EXEC_MODE), .HALT_MODE(HALT_MODE), .SUBCLK_SEL(SUBCLK_SEL), .EXC_DONE(EXC_DONE),
    .EXC_STACK_POINTER(EXC_STACK_POINTER), .REQ(REQ), .READY(READY),
    .WRITE(WRITE), .WORD(WORD), .ADDR(ADDR), .WDATA(WDATA), .BIT_EN(BIT_EN), .BIT_OP(BIT_OP),
    .BIT_NUM(BIT_NUM), .BIT_C(BIT_C), .DONE(DONE), .RDATA(RDATA), .EMPTY_WRITE(EMPTY_WRITE),
    .MEM_SEL(MEM_SEL), .MEM_WE(MEM_WE), .MEM_BE(MEM_BE), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .PER_SEL(PER_SEL), .PER_WE(PER_WE),
    .PER_ADDR(PER_ADDR), .PER_WDATA(PER_WDATA), .PER_RDATA(PER_RDATA),
    .PORT_PIN_IN(PORT_PIN_IN), .PORT_OUT(PORT_OUT), .PORT_OE(PORT_OE));
  mem_periph_model u_mem_periph_model (
    .clk(CLK_SYS), .mem_sel(MEM_SEL), .mem_we(MEM_WE), .mem_be(MEM_BE), .mem_addr(MEM_ADDR),
    .mem_wdata(MEM_WDATA), .mem_rdata(MEM_RDATA), .per_sel(PER_SEL), .per_we(PER_WE),
    .per_addr(PER_ADDR), .per_wdata(PER_WDATA), .per_rdata(PER_RDATA));
  // 125 MHz clock
  initial begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one access; op 7 means a plain transfer, lat 0 means no strobe, below 0 skips timing
  task automatic acc(input logic w, input logic wd, input logic [2:0] op, input logic [2:0] n,
                     input logic [15:0] a, input logic [15:0] d, input int lat);
    int k;
    int sel;
    k = 0;
    sel = 0;
    while (READY !== 1'b1 && k < 20) begin
      @(posedge CLK_SYS);
      #1;
      k++;
    end
    REQ = 1'b1;
    WRITE = w;
    WORD = wd;
    BIT_EN = (op != 3'h7);
    BIT_OP = op;
    BIT_NUM = n;
    ADDR = a;
    WDATA = d;
    @(posedge CLK_SYS);
    #1;
    REQ = 1'b0;
    BIT_EN = 1'b0;
    k = 1;
    sel = int'(MEM_SEL === 1'b1 || PER_SEL === 1'b1);
    while (DONE !== 1'b1 && k < 20) begin
      @(posedge CLK_SYS);
      #1;
      k++;
      if (MEM_SEL === 1'b1 || PER_SEL === 1'b1) sel++;
    end
    chk(16'(DONE), 16'h0001, "request completion");
    rd = RDATA;
    ew = EMPTY_WRITE;
    if (lat > 0) chk(16'(k), 16'(lat), "bus cycle length");
    if (lat >= 0) chk(16'(sel), 16'(lat > 0 ? lat - 1 : 0), "strobed states");
  endtask
  task automatic t_reset();
    chk(16'(CPU_STATE), 16'(CPU_RESET), "state in reset");
    RST = 1'b0;
    @(posedge CLK_SYS);
    #1;
    chk(16'(CPU_STATE), 16'(CPU_EXCEPT), "state after release");
    @(posedge CLK_SYS);
    #1;
    chk(16'(CPU_STATE), 16'(CPU_EXEC), "running state");
    chk(16'(EXC_DONE), 16'h0001, "reset exception end");
    $display("test reset done");
  endtask
  task automatic t_mem();
    acc(1'b1, 1'b1, 3'h7, 3'h0, 16'hff00, 16'h1234, 3);
    acc(1'b0, 1'b1, 3'h7, 3'h0, 16'hff00, 16'h0000, 3);
    chk(rd, 16'h1234, "word read");
    acc(1'b0, 1'b0, 3'h7, 3'h0, 16'hff01, 16'h0000, 3);
    chk(rd, 16'h0034, "odd byte read");
    acc(1'b1, 1'b0, 3'h7, 3'h0, 16'hff00, 16'h00ab, 3);
    acc(1'b0, 1'b1, 3'h7, 3'h0, 16'hff00, 16'h0000, 3);
    chk(rd, 16'hab34, "even byte write");
    $display("test memory done");
  endtask
  task automatic t_io();
    acc(1'b1, 1'b0, 3'h7, 3'h0, 16'hff85, 16'h005a, 3);
    acc(1'b0, 1'b0, 3'h7, 3'h0, 16'hff85, 16'h0000, 3);
    chk(rd, 16'h005a, "fast peripheral byte");
    acc(1'b1, 1'b0, 3'h7, 3'h0, 16'hffa4, 16'h00c3, 4);
    acc(1'b0, 1'b0, 3'h7, 3'h0, 16'hffa4, 16'h0000, 4);
    chk(rd, 16'h00c3, "slow peripheral byte");
    acc(1'b1, 1'b0, 3'h7, 3'h0, 16'hff87, 16'h0099, 3);
    acc(1'b1, 1'b1, 3'h7, 3'h0, 16'hff86, 16'h7e11, 3);
    acc(1'b0, 1'b0, 3'h7, 3'h0, 16'hff86, 16'h0000, 3);
    chk(rd, 16'h007e, "upper byte of word write");
    acc(1'b0, 1'b0, 3'h7, 3'h0, 16'hff87, 16'h0000, 3);
    chk(rd, 16'h0099, "lower byte dropped");
    acc(1'b0, 1'b1, 3'h7, 3'h0, 16'hff86, 16'h0000, 3);
    chk(rd, {8'h7e, UNDEF_BYTE}, "word read of peripheral");
    $display("test peripheral done");
  endtask
  task automatic t_empty();
    acc(1'b1, 1'b0, 3'h7, 3'h0, 16'h9000, 16'h0055, 0);
    chk(16'(ew), 16'h0001, "empty write flag");
    acc(1'b0, 1'b0, 3'h7, 3'h0, 16'h9000, 16'h0000, 0);
    chk(rd, {8'h00, UNDEF_BYTE}, "empty read");
    $display("test empty done");
  endtask
  task automatic t_bit();
    logic [2:0] nums [5] = '{3'h7, 3'h0, 3'h1, 3'h4, 3'h3};
    logic [7:0] exp [5] = '{8'h8f, 8'h8e, 8'h8c, 8'h9c, 8'h94};
    acc(1'b1, 1'b0, 3'h7, 3'h0, 16'hff10, 16'h000f, 3);
    BIT_C = 1'b1;
    // set, clear, invert, store and inverted store in turn
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, 1'b0, 3'(i), nums[i], 16'hff10, 16'h0000, 5);
      acc(1'b0, 1'b0, 3'h7, 3'h0, 16'hff10, 16'h0000, 3);
      chk(rd, {8'h00, exp[i]}, "bit operation result");
    end
    acc(1'b1, 1'b0, 3'h7, 3'h0, 16'hffa8, 16'h0000, 4);
    acc(1'b0, 1'b0, 3'h0, 3'h2, 16'hffa8, 16'h0000, 7);
    acc(1'b0, 1'b0, 3'h7, 3'h0, 16'hffa8, 16'h0000, 4);
    chk(rd, 16'h0004, "slow bit set");
    acc(1'b1, 1'b0, 3'h7, 3'h0, 16'hff90, 16'h0080, 3);
    acc(1'b0, 1'b0, 3'h0, 3'h0, 16'hff90, 16'h0000, 5);
    chk(16'(u_mem_periph_model.reload), 16'h003d, "reload from count");
    $display("test bit done");
  endtask
  task automatic t_port();
    acc(1'b1, 1'b0, 3'h7, 3'h0, PORT_DIR_ADDR, 16'h003f, -1);
    acc(1'b1, 1'b0, 3'h7, 3'h0, PORT_DATA_ADDR, 16'h0080, -1);
    acc(1'b0, 1'b0, 3'h7, 3'h0, PORT_DATA_ADDR, 16'h0000, -1);
    chk(rd, 16'h0040, "port data read");
    acc(1'b0, 1'b0, 3'h0, 3'h0, PORT_DATA_ADDR, 16'h0000, -1);
    chk(16'(PORT_OUT), 16'h0041, "port latch after bit set");
    acc(1'b0, 1'b0, 3'h7, 3'h0, PORT_DIR_ADDR, 16'h0000, -1);
    chk(rd, {8'h00, WO_READ}, "write-only read");
    acc(1'b0, 1'b0, 3'h1, 3'h0, PORT_DIR_ADDR, 16'h0000, -1);
    chk(16'(PORT_OE), 16'h00fe, "direction after bit clear");
    $display("test port done");
  endtask
  task automatic t_irq();
    int k;
    k = 0;
    STACK_POINTER = 16'hff40;
    PC = 16'h1234;
    CONDITION_FLAGS = 8'ha5;
    IRQ = 1'b1;
    while (EXC_DONE !== 1'b1 && k < 20) begin
      @(posedge CLK_SYS);
      #1;
      k++;
      if (k == 1) chk(16'(CPU_STATE), 16'(CPU_EXCEPT), "interrupt entry");
      if (k == 1) chk(16'(READY), 16'h0000, "no access while handling");
      IRQ = 1'b0;
    end
    chk(16'(k), 16'h0008, "exception length");
    chk(EXC_STACK_POINTER, 16'hff3c, "stack after pushes");
    acc(1'b0, 1'b1, 3'h7, 3'h0, 16'hff3e, 16'h0000, 3);
    chk(rd, 16'h1234, "pushed counter");
    acc(1'b0, 1'b1, 3'h7, 3'h0, 16'hff3c, 16'h0000, 3);
    chk(rd, 16'ha5a5, "pushed flags");
    $display("test interrupt done");
  endtask
  task automatic t_halt();
    int k;
    for (int m = 0; m < 4; m++) begin
      HALT_MODE_REQ = 2'(m);
      SLEEP_REQ = 1'b1;
      k = 0;
      while (CPU_STATE !== CPU_HALT && k < 10) begin
        @(posedge CLK_SYS);
        #1;
        k++;
      end
      SLEEP_REQ = 1'b0;
      @(posedge CLK_SYS);
      #1;
      chk(16'(HALT_MODE), 16'(m), "halt sub-mode");
      chk(16'(READY), 16'h0000, "no execution in halt");
      chk(16'(SUBCLK_SEL), 16'(m == 3), "halt clock source");
      WAKE = 1'b1;
      @(posedge CLK_SYS);
      #1;
      WAKE = 1'b0;
      @(posedge CLK_SYS);
      #1;
      chk(16'(CPU_STATE), 16'(CPU_EXEC), "woken");
    end
    for (int e = 0; e < 3; e++) begin
      EXEC_MODE_REQ = 2'(e);
      repeat (3) @(posedge CLK_SYS);
      #1;
      chk(16'(EXEC_MODE), 16'(e), "running mode");
      chk(16'(SUBCLK_SEL), 16'(e == 2), "running clock source");
    end
    EXEC_MODE_REQ = 2'h0;
    // an interrupt during halt leaves through exception handling
    SLEEP_REQ = 1'b1;
    repeat (2) @(posedge CLK_SYS);
    #1;
    {SLEEP_REQ, IRQ} = 2'b01;
    @(posedge CLK_SYS);
    #1;
    IRQ = 1'b0;
    chk(16'(CPU_STATE), 16'(CPU_EXCEPT), "interrupt in halt");
    $display("test halt done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {RST, IRQ, SLEEP_REQ, WAKE, REQ, WRITE, WORD, BIT_EN, BIT_C} = 9'h100;
    {HALT_MODE_REQ, EXEC_MODE_REQ, BIT_OP, BIT_NUM} = 10'h000;
    {PC, STACK_POINTER, ADDR, WDATA, CONDITION_FLAGS} = 72'h0;
    PORT_PIN_IN = 8'h40;
    repeat (3) @(posedge CLK_SYS);
    #1;
    t_reset();
    t_mem();
    t_io();
    t_empty();
    t_bit();
    t_port();
    t_irq();
    t_halt();
    complete_run();
  end
  // watchdog well beyond the expected run
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
